/* File: src/link_sync_params.svh */
`ifndef LINK_SYNC_PARAMS_SVH
`define LINK_SYNC_PARAMS_SVH
// sync source select encodings
`define SYNC_SEL_SINGLE_ENDED 2'h0
`define SYNC_SEL_TIMESTAMP 2'h1
`define SYNC_SEL_DEDICATED 2'h2
// length of alignment sequence in multiframes
`define ILAS_MULTIFRAMES 8'h04
// frames per multiframe, default
`define FRAMES_PER_MF 8'h20
// multiframe counter width
`define MF_CNT_W 8
`endif

/* File: src/link_sync_pkg.sv */
package link_sync_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CGS,
    ST_WAIT_RELEASE,
    ST_ILAS,
    ST_DATA,
    ST_FREE_RUN
  } link_state_t;
  typedef enum logic [1:0] {
    LANE_IDLE,
    LANE_CGS,
    LANE_ILAS,
    LANE_DATA
  } lane_mode_t;
endpackage

/* File: src/sync_in_if.sv */
`timescale 1ns/10ps
interface sync_in_if;
  logic request_low;
  logic rise;
  logic fall;
  modport filt (output request_low, output rise, output fall);
  modport seq (input request_low, input rise, input fall);
endinterface

/* File: src/sync_pin_filter.sv */
`timescale 1ns/10ps
`include "link_sync_params.svh"
module sync_pin_filter (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  sync_in_if.filt out
);
  logic s1_q, s1_d;
  logic s2_q, s2_d;
  logic s3_q, s3_d;
  logic lvl_q, lvl_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  // three stage capture; a change counts once stages two and three agree
  always_comb
  begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (s2_q == s3_q && s3_q != lvl_q)
    begin
      lvl_d = s3_q;
      rise_d = s3_q;
      fall_d = ~s3_q;
    end
  end

  // registers reset to pin high, i.e. no request
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  // low level is an asserted request
  assign out.request_low = ~lvl_q; // see RULE_02
  assign out.rise = rise_q;
  assign out.fall = fall_q;
endmodule // sync_pin_filter

/* File: src/serial_link_sync_request_input.sv */
// Functional notes
// RULE_01 - single-ended pin is the request source in 8B/10B when select is 0
// RULE_02 - request is active low; low level means synchronisation asked
// RULE_03 - in 64B/66B the request input is ignored entirely
// RULE_04 - in 8B/10B a low request starts code group synchronisation
// RULE_05 - rising request after CGS starts initial lane alignment sequence
// RULE_06 - pin unused when timestamp or dedicated input is the source
// RULE_07 - SYSREF used for synchronisation and deterministic latency
// RULE_08 - SYSREF receiver enable; clearing it powers receiver down
// RULE_09 - timestamp input may serve as differential request in 8b/10b
// RULE_10 - request low again after alignment restarts CGS on all lanes
`timescale 1ns/10ps
`include "link_sync_params.svh"
module serial_link_sync_request_input #(
  parameter logic [7:0] FRAMES_PER_MF = `FRAMES_PER_MF,
  parameter logic [7:0] ILAS_MULTIFRAMES = `ILAS_MULTIFRAMES
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic link_enable_in,
  input wire logic mode_64b66b_in,
  input wire logic [1:0] sync_source_select_in,
  input wire logic single_ended_sync_request_in,
  input wire logic timestamp_diff_input_in,
  input wire logic dedicated_diff_sync_request_in,
  input wire logic sysref_receiver_enable_in,
  input wire logic sysref_dc_coupling_select_in,
  input wire logic sysref_in,
  output logic [1:0] lane_mode_out,
  output logic multiframe_start_out,
  output logic sysref_receiver_power_out,
  output logic sysref_termination_dc_out,
  output logic sysref_aligned_out,
  output logic link_up_out
);
  sync_in_if se_if ();
  sync_in_if ts_if ();
  sync_in_if dd_if ();
  sync_in_if sr_if ();

  // one synchroniser per asynchronous request source and for SYSREF
  sync_pin_filter u_se (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(single_ended_sync_request_in),
    .out(se_if)
  );
  sync_pin_filter u_ts (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(timestamp_diff_input_in),
    .out(ts_if)
  );
  sync_pin_filter u_dd (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(dedicated_diff_sync_request_in),
    .out(dd_if)
  );
  // sysref is active high; a rising edge shows as fall of the inverted level
  sync_pin_filter u_sr (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(~(sysref_in & sysref_receiver_enable_in)), // see RULE_08
    .out(sr_if)
  );

  logic req_low;
  logic req_rise;
  logic req_fall;

  // select request source
  always_comb
  begin
    req_low = 1'b0;
    req_rise = 1'b0;
    req_fall = 1'b0;
    case (sync_source_select_in)
      `SYNC_SEL_SINGLE_ENDED:
      begin
        req_low = se_if.request_low; // see RULE_01
        req_rise = se_if.rise;
        req_fall = se_if.fall;
      end
      `SYNC_SEL_TIMESTAMP:
      begin
        req_low = ts_if.request_low; // see RULE_09
        req_rise = ts_if.rise; // see RULE_06
        req_fall = ts_if.fall;
      end
      `SYNC_SEL_DEDICATED:
      begin
        req_low = dd_if.request_low; // see RULE_06
        req_rise = dd_if.rise;
        req_fall = dd_if.fall;
      end
      default:
      begin
        req_low = 1'b0;
        req_rise = 1'b0;
        req_fall = 1'b0;
      end
    endcase
  end

  link_sync_pkg::link_state_t st_q, st_d;
  logic [7:0] frame_q, frame_d;
  logic [7:0] mf_q, mf_d;
  logic aligned_q, aligned_d;
  logic mfs_q, mfs_d;
  logic sysref_edge;

  assign sysref_edge = sr_if.fall;

  // link state sequencer and multiframe timing
  always_comb
  begin
    st_d = st_q;
    frame_d = frame_q + 8'h01;
    mf_d = mf_q;
    aligned_d = aligned_q;
    mfs_d = 1'b0;
    // sysref realigns the multiframe clock for deterministic latency
    if (sysref_edge)
    begin
      frame_d = 8'h00; // see RULE_07
      aligned_d = 1'b1;
    end
    else if (frame_q == FRAMES_PER_MF - 8'h01)
    begin
      frame_d = 8'h00;
    end
    if (frame_d == 8'h00)
    begin
      mfs_d = 1'b1;
    end
    if (!sysref_receiver_enable_in)
    begin
      aligned_d = 1'b0; // see RULE_08
    end
    case (st_q)
      link_sync_pkg::ST_IDLE:
      begin
        if (link_enable_in && mode_64b66b_in)
        begin
          st_d = link_sync_pkg::ST_FREE_RUN; // see RULE_03
        end
        else if (link_enable_in && req_low)
        begin
          st_d = link_sync_pkg::ST_CGS; // see RULE_04
        end
      end
      link_sync_pkg::ST_CGS:
      begin
        if (req_rise)
        begin
          st_d = link_sync_pkg::ST_WAIT_RELEASE; // see RULE_05
        end
      end
      link_sync_pkg::ST_WAIT_RELEASE:
      begin
        // ilas begins on the next multiframe boundary
        if (req_low)
        begin
          st_d = link_sync_pkg::ST_CGS;
        end
        else if (mfs_d)
        begin
          st_d = link_sync_pkg::ST_ILAS; // see RULE_05
          mf_d = 8'h00;
        end
      end
      link_sync_pkg::ST_ILAS:
      begin
        if (req_fall)
        begin
          st_d = link_sync_pkg::ST_CGS; // see RULE_10
        end
        else if (mfs_d)
        begin
          mf_d = mf_q + 8'h01;
          if (mf_q == ILAS_MULTIFRAMES - 8'h01)
          begin
            st_d = link_sync_pkg::ST_DATA;
          end
        end
      end
      link_sync_pkg::ST_DATA:
      begin
        if (req_fall)
        begin
          st_d = link_sync_pkg::ST_CGS; // see RULE_10
        end
      end
      link_sync_pkg::ST_FREE_RUN:
      begin
        // request input plays no part here
        st_d = link_sync_pkg::ST_FREE_RUN; // see RULE_03
      end
      default:
      begin
        st_d = link_sync_pkg::ST_IDLE;
      end
    endcase
    if (!link_enable_in)
    begin
      st_d = link_sync_pkg::ST_IDLE;
    end
    else if (st_q == link_sync_pkg::ST_FREE_RUN && !mode_64b66b_in)
    begin
      st_d = link_sync_pkg::ST_IDLE;
    end
    else if (st_q != link_sync_pkg::ST_FREE_RUN && mode_64b66b_in)
    begin
      st_d = link_sync_pkg::ST_FREE_RUN; // see RULE_03
    end
  end

  // sequencer registers
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= link_sync_pkg::ST_IDLE;
      frame_q <= 8'h00;
      mf_q <= 8'h00;
      aligned_q <= 1'b0;
      mfs_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      frame_q <= frame_d;
      mf_q <= mf_d;
      aligned_q <= aligned_d;
      mfs_q <= mfs_d;
    end
  end

  logic [1:0] lane_q, lane_d;

  // lane content decode
  always_comb
  begin
    case (st_d)
      link_sync_pkg::ST_CGS: lane_d = link_sync_pkg::LANE_CGS;
      link_sync_pkg::ST_WAIT_RELEASE: lane_d = link_sync_pkg::LANE_CGS;
      link_sync_pkg::ST_ILAS: lane_d = link_sync_pkg::LANE_ILAS;
      link_sync_pkg::ST_DATA: lane_d = link_sync_pkg::LANE_DATA;
      link_sync_pkg::ST_FREE_RUN: lane_d = link_sync_pkg::LANE_DATA;
      default: lane_d = link_sync_pkg::LANE_IDLE;
    endcase
  end

  // lane mode register
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      lane_q <= link_sync_pkg::LANE_IDLE;
    end
    else
    begin
      lane_q <= lane_d;
    end
  end

  // outputs
  assign lane_mode_out = lane_q;
  assign multiframe_start_out = mfs_q;
  assign sysref_receiver_power_out = sysref_receiver_enable_in; // see RULE_08
  assign sysref_termination_dc_out = sysref_dc_coupling_select_in;
  assign sysref_aligned_out = aligned_q;
  assign link_up_out = (lane_q == link_sync_pkg::LANE_DATA);
endmodule // serial_link_sync_request_input

/* File: sim/link_sync_sva.sv */
`timescale 1ns/10ps
module link_sync_sva (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic link_enable_in,
  input wire logic mode_64b66b_in,
  input wire logic [1:0] sync_source_select_in,
  input wire logic single_ended_sync_request_in,
  input wire logic sysref_receiver_enable_in,
  input wire logic sysref_dc_coupling_select_in,
  input wire logic [1:0] lane_mode_out,
  input wire logic sysref_receiver_power_out,
  input wire logic sysref_termination_dc_out,
  input wire logic sysref_aligned_out,
  input wire logic link_up_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // a low pin held long enough must put the lanes in cgs
  cgs_entry_a: assert property (
    (!single_ended_sync_request_in && sync_source_select_in == 2'h0
     && !mode_64b66b_in && link_enable_in)[*7] |-> lane_mode_out == 2'h1)
    else $error("low request did not start cgs");
  ilas_order_a: assert property (
    lane_mode_out == 2'h2 && $past(lane_mode_out) != 2'h2
    |-> $past(lane_mode_out) == 2'h1) else $error("ilas not after cgs");
  free_run_a: assert property (
    (mode_64b66b_in && link_enable_in)[*4] |-> lane_mode_out == 2'h3)
    else $error("64b66b mode not free running");
  idle_force_a: assert property (
    (!link_enable_in && !mode_64b66b_in)[*3] |-> lane_mode_out == 2'h0)
    else $error("disabled link not idle");
  link_up_a: assert property (
    link_up_out == (lane_mode_out == 2'h3)) else $error("link up wrong");
  power_copy_a: assert property (
    sysref_receiver_power_out == sysref_receiver_enable_in)
    else $error("sysref power differs from enable");
  aligned_off_a: assert property (
    !sysref_receiver_enable_in |=> !sysref_aligned_out)
    else $error("aligned kept with receiver off");
  term_copy_a: assert property (
    sysref_termination_dc_out == sysref_dc_coupling_select_in)
    else $error("termination differs from select");
endmodule // link_sync_sva
bind serial_link_sync_request_input link_sync_sva link_sync_sva_i (
  .clock_in, .sys_rst_in, .link_enable_in, .mode_64b66b_in,
  .sync_source_select_in, .single_ended_sync_request_in,
  .sysref_receiver_enable_in, .sysref_dc_coupling_select_in, .lane_mode_out,
  .sysref_receiver_power_out, .sysref_termination_dc_out,
  .sysref_aligned_out, .link_up_out);

/* File: sim/sync_receiver_model.sv */
`timescale 1ns/10ps
module sync_receiver_model (
  input wire logic clock_in,
  input wire logic request_in,
  input wire logic [2:0] hold_in,
  input wire logic [1:0] lane_mode_in,
  output logic sync_n_out
);
  logic [2:0] cnt_q = 3'h0;
  initial sync_n_out = 1'h1;
  // pull the request low, release it once cgs has been seen a while
  always @(posedge clock_in)
    if (request_in)
    begin
      sync_n_out <= 1'h0;
      cnt_q <= 3'h0;
    end
    else if (!sync_n_out && lane_mode_in == 2'h1)
    begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == hold_in)
        sync_n_out <= 1'h1;
    end
endmodule // sync_receiver_model

/* File: sim/tb_serial_link_sync_request_input.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_serial_link_sync_request_input;
  logic clock_in = 1'h0, sys_rst_in = 1'h1, en = 1'h0, m64 = 1'h0;
  logic dcsel = 1'h0, sr_en = 1'h0, sysref = 1'h0, req = 1'h0;
  logic sync_n, pwr, term, algn, up;
  logic [1:0] sel = 2'h0, lane, last = 2'h0, exp_lane;
  logic [31:0] rnd = 32'h49;
  logic mfs;
  logic [7:0] n_mf = 8'h00;
  logic [1:0] q[$];
  int n_errors = 0, num_checks = 0, i;
  // unselected pins carry noise
  wire logic se = sel == 2'h0 ? sync_n : rnd[0];
  wire logic ts = sel == 2'h1 ? sync_n : rnd[1];
  wire logic dd = sel == 2'h2 ? sync_n : rnd[2];
  serial_link_sync_request_input #(.FRAMES_PER_MF(8'h04),
    .ILAS_MULTIFRAMES(8'h02)) serial_link_sync_request_input_i (
    .clock_in, .sys_rst_in, .link_enable_in(en), .mode_64b66b_in(m64),
    .sync_source_select_in(sel), .single_ended_sync_request_in(se),
    .timestamp_diff_input_in(ts), .dedicated_diff_sync_request_in(dd),
    .sysref_receiver_enable_in(sr_en), .sysref_dc_coupling_select_in(dcsel),
    .sysref_in(sysref), .lane_mode_out(lane), .multiframe_start_out(mfs),
    .sysref_receiver_power_out(pwr), .sysref_termination_dc_out(term),
    .sysref_aligned_out(algn), .link_up_out(up));
  sync_receiver_model sync_receiver_model_i (.clock_in, .request_in(req),
    .hold_in(rnd[6:4]), .lane_mode_in(lane), .sync_n_out(sync_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  initial forever #4 clock_in = ~clock_in;
  // noise source steps each falling edge
  always @(negedge clock_in) rnd <= xs(rnd);
  // dc coupling select follows the noise
  always @(negedge clock_in) dcsel <= rnd[9];
  // each lane mode change takes the oldest expected note
  always @(negedge clock_in)
    if (!sys_rst_in && lane !== last)
    begin
      last = lane;
      exp_lane = q.size() != 0 ? q.pop_front() : ~lane;
      `CHK("lane mode", exp_lane, lane)
    end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for all expected changes
  task automatic drain();
    for (i = 0; i < 400 && q.size() != 0; i++)
      cyc(1);
    if (q.size() != 0)
    begin
      n_errors++;
      finish_test();
    end
  endtask
  // request sync and expect cgs, ilas, data
  task automatic sync_run();
    q.push_back(2'h1);
    q.push_back(2'h2);
    q.push_back(2'h3);
    req = 1'h1;
    cyc(1);
    req = 1'h0;
    drain();
  endtask
  // main sequence
  initial
  begin
    cyc(10);
    sys_rst_in = 1'h0;
    en = 1'h1;
    sr_en = 1'h1;
    // random sysref; a settled rising edge must align the multiframe clock
    for (i = 0; i < 60 && algn !== 1'h1; i++)
    begin
      sysref = rnd[3];
      cyc(1);
    end
    `CHK("aligned", 1'h1, algn)
    sysref = 1'h0;
    sr_en = 1'h0;
    cyc(2);
    `CHK("aligned off", 1'h0, algn)
    `CHK("power", 1'h0, pwr)
    `CHK("termination", dcsel, term)
    sr_en = 1'h1;
    for (int s = 0; s < 3; s++)
    begin
      // change source with the link off so stale filter history is flushed
      en = 1'h0;
      sel = 2'(s);
      if (s != 0)
        q.push_back(2'h0);
      drain();
      cyc(5);
      en = 1'h1;
      sync_run();
      sync_run();
    end
    `CHK("link up", 1'h1, up)
    en = 1'h0;
    q.push_back(2'h0);
    drain();
    sel = 2'h3;
    en = 1'h1;
    req = 1'h1;
    cyc(1);
    req = 1'h0;
    cyc(40);
    `CHK("no source", 2'h0, lane)
    m64 = 1'h1;
    q.push_back(2'h3);
    drain();
    sel = 2'h0;
    cyc(40);
    `CHK("free run", 2'h3, lane)
    // one start pulse every four cycles without sysref edges
    for (i = 0; i < 16; i++)
    begin
      cyc(1);
      n_mf = n_mf + {7'h00, mfs};
    end
    `CHK("multiframe starts", 8'h04, n_mf)
    finish_test();
  end
endmodule // tb_serial_link_sync_request_input
